//--- pkg/owsm_pkg.sv
// Constants and types for the single-wire sensor memory command slave
// Contract
// - Wait 15-60 us, then presence 60-240 us
// - Command 4Eh writes bytes at addresses 2,3
// - Reset aborts threshold write
// - Command BEh reads bytes 0..8, CRC last
// - Reset abandons scratch read
// - Command 48h copies only addresses 2,3
// - Copy status reads 0 busy, 1 done
// - Command 44h converts once, then idles
// - Conversion status reads 0 busy, 1 done
// - Conversion finishes within 500 ms
// - Recall B8h and power-up load thresholds
// - After recall, reads return converter ready
// - Command B4h reads supply mode
// - Sample write slot 15 to 60 us
// - Read bit held 15 us, then released
// - ROM byte precedes any memory command
package owsm_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned RST_MIN_US = 480;
	localparam int unsigned PRES_WAIT_US = 30;
	localparam int unsigned PRES_LEN_US = 120;
	localparam int unsigned WR_SMP_US = 30;
	localparam int unsigned RD_HOLD_US = 15;
	localparam int unsigned CONV_MS = 500;
	localparam int unsigned COPY_MS = 10;
	localparam int unsigned RST_MIN_CYC = RST_MIN_US * CLK_MHZ;
	localparam int unsigned PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
	localparam int unsigned PRES_LEN_CYC = PRES_LEN_US * CLK_MHZ;
	localparam int unsigned WR_SMP_CYC = WR_SMP_US * CLK_MHZ;
	localparam int unsigned RD_HOLD_CYC = RD_HOLD_US * CLK_MHZ;
	localparam int unsigned CONV_CYC = CONV_MS * 1000 * CLK_MHZ;
	localparam int unsigned COPY_CYC = COPY_MS * 1000 * CLK_MHZ;
	localparam logic [7:0] CMD_WRITE = 8'h4e;
	localparam logic [7:0] CMD_READ = 8'hbe;
	localparam logic [7:0] CMD_COPY = 8'h48;
	localparam logic [7:0] CMD_CONV = 8'h44;
	localparam logic [7:0] CMD_RECALL = 8'hb8;
	localparam logic [7:0] CMD_SUPPLY = 8'hb4;
	localparam logic [3:0] ADDR_UPPER = 4'h2;
	localparam logic [3:0] ADDR_LOWER = 4'h3;
	localparam logic [3:0] ADDR_CRC = 4'h8;
	localparam logic [7:0] RSVD_BYTE = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h8c;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TEMP = 8'h04;
	localparam logic [7:0] REG_NV = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam int unsigned CTRL_EXT_BIT = 0;
	localparam int unsigned STAT_CONV_BIT = 0;
	localparam int unsigned STAT_COPY_BIT = 1;
	localparam logic [7:0] NV_UPPER_RST = 8'h00;
	localparam logic [7:0] NV_LOWER_RST = 8'h00;
	localparam logic [31:0] TEMP_RST = 32'h0000_0000;
	typedef struct packed {
		logic [7:0] lower_alarm_threshold;
		logic [7:0] upper_alarm_threshold;
	} owsm_thr_t;
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_SLOT = 2'b01, S_PWAIT = 2'b11, S_PDRV = 2'b10} owsm_slot_t;
	typedef enum logic [2:0] {
		PR_IDLE = 3'b000, PR_ROM = 3'b001, PR_CMD = 3'b011, PR_WR = 3'b010,
		PR_RD = 3'b110, PR_STAT = 3'b111, PR_ONES = 3'b101
	} owsm_proto_t;
	typedef enum logic [1:0] {SEL_CONV = 2'b00, SEL_COPY = 2'b01, SEL_SUPPLY = 2'b11} owsm_sel_t;
endpackage : owsm_pkg

//--- verilog/owsm_slave.sv
// Single-wire sensor slave: slots, presence, memory commands, APB registers
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module owsm_slave #(
	parameter int unsigned RST_CYC = owsm_pkg::RST_MIN_CYC,
	parameter int unsigned PLEN_CYC = owsm_pkg::PRES_LEN_CYC,
	parameter int unsigned CONV_CYC = owsm_pkg::CONV_CYC,
	parameter int unsigned COPY_CYC = owsm_pkg::COPY_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic line_i,
	output logic line_o,
	output logic line_oe
);
	owsm_pkg::owsm_slot_t st_q, st_d;
	owsm_pkg::owsm_proto_t proto_q, proto_d;
	owsm_pkg::owsm_sel_t sel_q, sel_d;
	owsm_pkg::owsm_thr_t thr_q, thr_d, nv_q, nv_d;
	logic [31:0] cnt_q, cnt_d, low_q, low_d, conv_q, conv_d, copy_q, copy_d;
	logic [31:0] scr_q, scr_d, temp_q, temp_d, prdata_q, prdata_d;
	logic [7:0] sh_q, sh_d, nb, cur_byte, crc;
	logic [3:0] addr_q, addr_d;
	logic [2:0] bit_q, bit_d;
	logic lprev_q, oe_q, oe_d, ext_q, ext_d;
	logic rise, fall, rst_seen, take, rd_mode, tx_bit, conv_busy, copy_busy;
	logic acc, wr, mapped;

	// CRC over the eight scratch bytes, byte 0 first, each byte LSB first
	function automatic logic [7:0] crc8(input logic [63:0] d);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 0; i < 64; i++) begin
			fb = c[0] ^ d[i];
			c = {1'b0, c[7:1]};
			if (fb) begin
				c = c ^ owsm_pkg::CRC_POLY;
			end
		end
		return c;
	endfunction : crc8

	// Scratch image: temperature latched at conversion end, thresholds live
	always_comb begin
		crc = crc8({scr_q[31:16], owsm_pkg::RSVD_BYTE, owsm_pkg::RSVD_BYTE,
			thr_q.lower_alarm_threshold, thr_q.upper_alarm_threshold, scr_q[15:0]});
		case (addr_q)
			4'h0: cur_byte = scr_q[7:0];
			4'h1: cur_byte = scr_q[15:8];
			owsm_pkg::ADDR_UPPER: cur_byte = thr_q.upper_alarm_threshold;
			owsm_pkg::ADDR_LOWER: cur_byte = thr_q.lower_alarm_threshold;
			4'h6: cur_byte = scr_q[23:16];
			4'h7: cur_byte = scr_q[31:24];
			owsm_pkg::ADDR_CRC: cur_byte = crc;
			default: cur_byte = owsm_pkg::RSVD_BYTE;
		endcase
	end

	// Line events and the bit the device offers in a read slot
	assign rise = !lprev_q && line_i;
	assign fall = lprev_q && !line_i;
	assign rst_seen = rise && (low_q >= RST_CYC);
	assign take = (st_q == owsm_pkg::S_SLOT) && (cnt_q == owsm_pkg::WR_SMP_CYC);
	assign conv_busy = (conv_q != 32'h0);
	assign copy_busy = (copy_q != 32'h0);
	assign rd_mode = (proto_q == owsm_pkg::PR_RD) || (proto_q == owsm_pkg::PR_STAT) ||
		(proto_q == owsm_pkg::PR_ONES);
	always_comb begin
		case (proto_q)
			owsm_pkg::PR_RD: tx_bit = cur_byte[bit_q];
			owsm_pkg::PR_STAT: begin
				case (sel_q)
					owsm_pkg::SEL_CONV: tx_bit = !conv_busy;
					owsm_pkg::SEL_COPY: tx_bit = !copy_busy;
					default: tx_bit = ext_q;
				endcase
			end
			default: tx_bit = 1'b1;
		endcase
	end

	// Link next state: slot timing, presence, command decode, busy timers
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		proto_d = proto_q;
		sel_d = sel_q;
		sh_d = sh_q;
		bit_d = bit_q;
		addr_d = addr_q;
		thr_d = thr_q;
		nv_d = nv_q;
		scr_d = scr_q;
		nb = {line_i, sh_q[7:1]};
		low_d = line_i ? 32'h0 : ((low_q == 32'hffff_ffff) ? low_q : low_q + 32'h1);
		conv_d = conv_busy ? conv_q - 32'h1 : conv_q;
		copy_d = copy_busy ? copy_q - 32'h1 : copy_q;
		if (conv_q == 32'h1) begin
			scr_d = temp_q;
		end
		if (copy_q == 32'h1) begin
			nv_d = thr_q;
		end
		case (st_q)
			owsm_pkg::S_IDLE: begin
				if (fall) begin
					st_d = owsm_pkg::S_SLOT;
					cnt_d = 32'h0;
				end
			end
			owsm_pkg::S_SLOT: begin
				cnt_d = cnt_q + 32'h1;
				// Leave only after the sample point so a slow write one is not cut short
				if (cnt_q >= owsm_pkg::WR_SMP_CYC && line_i) begin
					st_d = owsm_pkg::S_IDLE;
				end
			end
			owsm_pkg::S_PWAIT: begin
				cnt_d = cnt_q + 32'h1;
				if (cnt_q == owsm_pkg::PRES_WAIT_CYC - 1) begin
					st_d = owsm_pkg::S_PDRV;
					cnt_d = 32'h0;
				end
			end
			owsm_pkg::S_PDRV: begin
				cnt_d = cnt_q + 32'h1;
				if (cnt_q == PLEN_CYC - 1) begin
					st_d = owsm_pkg::S_IDLE;
				end
			end
			default: st_d = owsm_pkg::S_IDLE;
		endcase
		// Write slots sample the line once, mid window; read slots advance the bit here
		if (take) begin
			bit_d = bit_q + 3'h1;
			sh_d = nb;
			if (bit_q == 3'h7) begin
				case (proto_q)
					owsm_pkg::PR_ROM: proto_d = owsm_pkg::PR_CMD;
					owsm_pkg::PR_CMD: begin
						case (nb)
							owsm_pkg::CMD_WRITE: begin
								addr_d = owsm_pkg::ADDR_UPPER;
								proto_d = owsm_pkg::PR_WR;
							end
							owsm_pkg::CMD_READ: begin
								addr_d = 4'h0;
								proto_d = owsm_pkg::PR_RD;
							end
							owsm_pkg::CMD_COPY: begin
								copy_d = COPY_CYC;
								sel_d = owsm_pkg::SEL_COPY;
								proto_d = owsm_pkg::PR_STAT;
							end
							owsm_pkg::CMD_CONV: begin
								conv_d = CONV_CYC;
								sel_d = owsm_pkg::SEL_CONV;
								proto_d = owsm_pkg::PR_STAT;
							end
							owsm_pkg::CMD_RECALL: begin
								thr_d = nv_q;
								sel_d = owsm_pkg::SEL_CONV;
								proto_d = owsm_pkg::PR_STAT;
							end
							owsm_pkg::CMD_SUPPLY: begin
								sel_d = owsm_pkg::SEL_SUPPLY;
								proto_d = owsm_pkg::PR_STAT;
							end
							default: proto_d = owsm_pkg::PR_IDLE;
						endcase
					end
					owsm_pkg::PR_WR: begin
						if (addr_q == owsm_pkg::ADDR_UPPER) begin
							thr_d.upper_alarm_threshold = nb;
							addr_d = owsm_pkg::ADDR_LOWER;
						end else begin
							thr_d.lower_alarm_threshold = nb;
							proto_d = owsm_pkg::PR_IDLE;
						end
					end
					owsm_pkg::PR_RD: begin
						if (addr_q == owsm_pkg::ADDR_CRC) begin
							proto_d = owsm_pkg::PR_ONES;
						end else begin
							addr_d = addr_q + 4'h1;
						end
					end
					default: proto_d = proto_q;
				endcase
			end
		end
		// A long low overrides everything: any write or read in flight is dropped
		if (rst_seen) begin
			st_d = owsm_pkg::S_PWAIT;
			cnt_d = 32'h0;
			proto_d = owsm_pkg::PR_ROM;
			bit_d = 3'h0;
		end
		oe_d = (st_d == owsm_pkg::S_PDRV) || ((st_d == owsm_pkg::S_SLOT) && rd_mode && !tx_bit &&
			(cnt_d < owsm_pkg::RD_HOLD_CYC));
	end

	// Link registers; thresholds come up holding the stored values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= owsm_pkg::S_IDLE;
			cnt_q <= 32'h0;
			low_q <= 32'h0;
			proto_q <= owsm_pkg::PR_IDLE;
			sel_q <= owsm_pkg::SEL_CONV;
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			addr_q <= 4'h0;
			thr_q <= {owsm_pkg::NV_LOWER_RST, owsm_pkg::NV_UPPER_RST};
			nv_q <= {owsm_pkg::NV_LOWER_RST, owsm_pkg::NV_UPPER_RST};
			scr_q <= owsm_pkg::TEMP_RST;
			conv_q <= 32'h0;
			copy_q <= 32'h0;
			lprev_q <= 1'b1;
			oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			low_q <= low_d;
			proto_q <= proto_d;
			sel_q <= sel_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			addr_q <= addr_d;
			thr_q <= thr_d;
			nv_q <= nv_d;
			scr_q <= scr_d;
			conv_q <= conv_d;
			copy_q <= copy_d;
			lprev_q <= line_i;
			oe_q <= oe_d;
		end
	end
	// Open drain: the pin only ever pulls low
	assign line_o = 1'b0;
	assign line_oe = oe_q;

	// APB: zero wait states, read data captured in the setup cycle
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign mapped = (paddr == owsm_pkg::REG_CTRL) || (paddr == owsm_pkg::REG_TEMP) ||
		(paddr == owsm_pkg::REG_NV) || (paddr == owsm_pkg::REG_STAT);
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata = prdata_q;
	always_comb begin
		ext_d = ext_q;
		temp_d = temp_q;
		prdata_d = prdata_q;
		if (wr && paddr == owsm_pkg::REG_CTRL) begin
			ext_d = pwdata[owsm_pkg::CTRL_EXT_BIT];
		end
		if (wr && paddr == owsm_pkg::REG_TEMP) begin
			temp_d = pwdata;
		end
		if (psel && !penable && !pwrite) begin
			case (paddr)
				owsm_pkg::REG_CTRL: prdata_d = {31'h0, ext_q};
				owsm_pkg::REG_TEMP: prdata_d = temp_q;
				owsm_pkg::REG_NV: prdata_d = {16'h0, nv_q};
				owsm_pkg::REG_STAT: prdata_d = {1'b0, proto_q, 4'h0, thr_q, 6'h0, copy_busy, conv_busy};
				default: prdata_d = 32'h0;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q <= 1'b0;
			temp_q <= owsm_pkg::TEMP_RST;
			prdata_q <= 32'h0;
		end else begin
			ext_q <= ext_d;
			temp_q <= temp_d;
			prdata_q <= prdata_d;
		end
	end

	// Checks on the link behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	pres_wait_a: assert property (rst_seen |=> st_q == owsm_pkg::S_PWAIT && !line_oe) else $error("no presence wait");
	pres_drive_a: assert property ($rose(st_q == owsm_pkg::S_PDRV) |-> $past(cnt_q) == owsm_pkg::PRES_WAIT_CYC - 1 && line_oe)
		else $error("presence start wrong");
	wr_start_a: assert property (take && bit_q == 3'h7 && proto_q == owsm_pkg::PR_CMD && nb == owsm_pkg::CMD_WRITE
		|=> addr_q == owsm_pkg::ADDR_UPPER && proto_q == owsm_pkg::PR_WR) else $error("write start wrong");
	reset_abort_a: assert property (rst_seen |=> proto_q == owsm_pkg::PR_ROM && bit_q == 3'h0) else $error("abort failed");
	rd_start_a: assert property (take && bit_q == 3'h7 && proto_q == owsm_pkg::PR_CMD && nb == owsm_pkg::CMD_READ
		|=> addr_q == 4'h0 && proto_q == owsm_pkg::PR_RD) else $error("read start wrong");
	copy_store_a: assert property ($fell(copy_busy) |-> nv_q == $past(thr_q)) else $error("copy lost thresholds");
	conv_bit_a: assert property (proto_q == owsm_pkg::PR_STAT && sel_q == owsm_pkg::SEL_CONV |-> tx_bit == !conv_busy)
		else $error("conversion status wrong");
	copy_bit_a: assert property (proto_q == owsm_pkg::PR_STAT && sel_q == owsm_pkg::SEL_COPY |-> tx_bit == !copy_busy)
		else $error("copy status wrong");
	conv_bound_a: assert property (conv_q <= CONV_CYC) else $error("conversion too long");
	supply_bit_a: assert property (proto_q == owsm_pkg::PR_STAT && sel_q == owsm_pkg::SEL_SUPPLY |-> tx_bit == ext_q)
		else $error("supply status wrong");
	rd_hold_a: assert property (line_oe && st_q == owsm_pkg::S_SLOT |-> cnt_q < owsm_pkg::RD_HOLD_CYC) else $error("held too long");
	ones_a: assert property (proto_q == owsm_pkg::PR_ONES |-> tx_bit ##1 proto_q == owsm_pkg::PR_ONES || rst_seen || $past(rst_seen))
		else $error("ones expected");
	presence_c: cover property ($fell(st_q == owsm_pkg::S_PDRV));
	crc_done_c: cover property (proto_q == owsm_pkg::PR_RD ##1 proto_q == owsm_pkg::PR_ONES);
	copy_done_c: cover property ($fell(copy_busy));
endmodule : owsm_slave
`default_nettype wire

//--- dv/owsm_master_model.sv
// Bus master model for the single-wire line: reset pulse, presence timing, slots
`timescale 1ns/1ps
`default_nettype none
module owsm_master_model #(
	parameter int unsigned RST_LOW = 12000
) (
	input wire logic pclk,
	input wire logic line,
	output logic pull_low
);
	localparam int unsigned SLOT = 7500;
	localparam int unsigned REC = 125;
	initial pull_low = 1'b0;
	// Reset pulse, then time the wait and length of the presence answer
	task automatic reset_pulse(output int wait_c, output int len_c);
		pull_low <= 1'b1;
		repeat (RST_LOW) @(posedge pclk);
		pull_low <= 1'b0;
		wait_c = 0;
		len_c = 0;
		do begin
			@(posedge pclk);
			wait_c++;
		end while (line !== 1'b0 && wait_c < 10000);
		while (line === 1'b0 && len_c < 40000) begin
			@(posedge pclk);
			len_c++;
		end
		repeat (1000) @(posedge pclk);
	endtask : reset_pulse
	// One slot: low for lo cycles, line sampled before 15 us; slot always lasts 60 us
	task automatic slot(input int lo, output logic smp_v);
		pull_low <= 1'b1;
		for (int i = 1; i <= SLOT; i++) begin
			@(posedge pclk);
			if (i == lo) pull_low <= 1'b0;
			if (i == 1500) smp_v = line;
		end
		repeat (REC) @(posedge pclk);
	endtask : slot
	// Bytes go out least significant bit first
	task automatic write_byte(input logic [7:0] v);
		logic s;
		for (int i = 0; i < 8; i++) slot(v[i] ? 125 : SLOT, s);
	endtask : write_byte
	task automatic read_byte(output logic [7:0] v);
		for (int i = 0; i < 8; i++) slot(125, v[i]);
	endtask : read_byte
endmodule : owsm_master_model
`default_nettype wire

//--- dv/onewire_sensor_memory_commands_tb.sv
// Self-checking bench for the single-wire sensor slave with APB register access
`timescale 1ns/1ps
`default_nettype none
module onewire_sensor_memory_commands_tb;
	// Shortened device timing so that the run stays short; reset threshold sits below the model's pulse
	localparam int PLEN = 100;
	localparam int unsigned RST_C = 10000;
	localparam int unsigned BUSY_C = 20000;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_o, line_oe, pull_low, er, b;
	logic [7:0] paddr, v, crc;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] exp_b [0:8] = '{8'h34, 8'h12, 8'ha5, 8'h3c, 8'hff, 8'hff, 8'h55, 8'haa, 8'h00};
	int error_cnt = 0;
	int checks = 0;
	wire line_w;
	// Open-drain wire with pull-up: low whenever either party pulls
	assign line_w = ~(pull_low | (line_oe & ~line_o));
	owsm_slave #(.RST_CYC(RST_C), .PLEN_CYC(PLEN), .CONV_CYC(BUSY_C), .COPY_CYC(BUSY_C)) owsm_slave_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_i(line_w),
		.line_o(line_o), .line_oe(line_oe));
	owsm_master_model owsm_master_model_inst (.pclk(pclk), .line(line_w), .pull_low(pull_low));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One APB transfer; the request holds until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Reset, presence check, selection byte, then the command byte
	task automatic session(input logic [7:0] cmd);
		int w;
		int l;
		owsm_master_model_inst.reset_pulse(w, l);
		chk("presence wait", 32'h1, 32'(w >= 1875 && w <= 7500));
		chk("presence length", 32'h1, 32'(l >= PLEN - 2 && l <= PLEN + 2));
		owsm_master_model_inst.write_byte(8'hcc);
		owsm_master_model_inst.write_byte(cmd);
	endtask : session
	// First read slot shows busy, the status register agrees, then ready comes
	task automatic busy_then_ready(input string nm, input int idx);
		int n;
		owsm_master_model_inst.slot(125, b);
		chk(nm, 32'h0, 32'(b));
		apb(1'b0, owsm_pkg::REG_STAT, 32'h0);
		chk("stat busy", 32'h1, 32'(rd[idx]));
		n = 0;
		do begin
			owsm_master_model_inst.slot(125, b);
			n++;
		end while (b !== 1'b1 && n < 8);
		chk(nm, 32'h1, 32'(b));
	endtask : busy_then_ready
	task automatic summarize();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	// Watchdog: the sequence needs about 19 ms of simulated time
	initial begin
		#60000000;
		error_cnt++;
		summarize();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		crc = 8'h00;
		// Expected check byte: reflected CRC-8 over bytes 0..7, least significant bit first
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 8; j++) begin
				crc = ((crc ^ (exp_b[i] >> j)) & 8'h01) ? ((crc >> 1) ^ owsm_pkg::CRC_POLY) : (crc >> 1);
			end
		end
		exp_b[8] = crc;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, owsm_pkg::REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b0, owsm_pkg::REG_NV, 32'h0);
		chk("nv reset", 32'h0, rd);
		apb(1'b0, owsm_pkg::REG_STAT, 32'h0);
		chk("thresholds at power-up", 32'h0, {16'h0, rd[23:8]});
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", 32'h1, 32'(er));
		apb(1'b1, owsm_pkg::REG_TEMP, 32'haa55_1234);
		apb(1'b0, owsm_pkg::REG_TEMP, 32'h0);
		chk("temp rw", 32'haa55_1234, rd);
		chk("mapped no error", 32'h0, 32'(er));
		session(owsm_pkg::CMD_SUPPLY);
		owsm_master_model_inst.slot(125, b);
		chk("supply line-powered", 32'h0, 32'(b));
		// External supply from here on, so no strong pull-up periods are owed
		apb(1'b1, owsm_pkg::REG_CTRL, 32'h1);
		session(owsm_pkg::CMD_SUPPLY);
		owsm_master_model_inst.slot(125, b);
		chk("supply external", 32'h1, 32'(b));
		session(owsm_pkg::CMD_CONV);
		busy_then_ready("conversion status", owsm_pkg::STAT_CONV_BIT);
		session(owsm_pkg::CMD_WRITE);
		owsm_master_model_inst.write_byte(8'ha5);
		owsm_master_model_inst.write_byte(8'h3c);
		owsm_master_model_inst.write_byte(8'h99);
		apb(1'b0, owsm_pkg::REG_STAT, 32'h0);
		chk("written thresholds", 32'h3ca5, {16'h0, rd[23:8]});
		session(owsm_pkg::CMD_READ);
		for (int i = 0; i < 9; i++) begin
			owsm_master_model_inst.read_byte(v);
			chk("scratch byte", 32'(exp_b[i]), 32'(v));
		end
		owsm_master_model_inst.read_byte(v);
		chk("after check byte", 32'hff, 32'(v));
		session(owsm_pkg::CMD_COPY);
		busy_then_ready("copy status", owsm_pkg::STAT_COPY_BIT);
		apb(1'b0, owsm_pkg::REG_NV, 32'h0);
		chk("stored thresholds", 32'h3ca5, {16'h0, rd[15:0]});
		session(owsm_pkg::CMD_WRITE);
		owsm_master_model_inst.write_byte(8'h77);
		session(owsm_pkg::CMD_READ);
		for (int i = 0; i < 4; i++) owsm_master_model_inst.read_byte(exp_b[i]);
		chk("aborted write upper", 32'h77, 32'(exp_b[2]));
		chk("aborted write lower", 32'h3c, 32'(exp_b[3]));
		session(owsm_pkg::CMD_RECALL);
		owsm_master_model_inst.slot(125, b);
		chk("recall ready", 32'h1, 32'(b));
		apb(1'b0, owsm_pkg::REG_STAT, 32'h0);
		chk("recalled thresholds", 32'h3ca5, {16'h0, rd[23:8]});
		summarize();
	end
endmodule : onewire_sensor_memory_commands_tb
`default_nettype wire
